// file: hdl/pcor_option_regs.sv
`timescale 1ns/1ps
module pcor_option_regs #(
  parameter int UV5_DELAY_A_CYC = pcor_pkg::UV5_DELAY_A_CYC,
  parameter int UV5_DELAY_B_CYC = pcor_pkg::UV5_DELAY_B_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic i_WR_EN,
  input wire logic [7:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  input wire logic [7:0] i_RADDR,
  input wire pcor_pkg::pcor_fuse_s i_FUSE,
  input wire logic i_CH3_CH4_ENABLE_PIN,
  input wire logic i_MANUAL_ON_CH3,
  input wire logic i_MANUAL_ON_CH4,
  input wire logic [pcor_pkg::DELAY_W-1:0] i_COMMON_UV_DELAY_CYC,
  input wire logic [pcor_pkg::DIS_DELAY_W-1:0] i_DISABLE_DELAY_CYC,
  output logic o_READY,
  output logic [7:0] o_RDATA,
  output logic [5:0] o_SLOW_EDGES,
  output logic [5:0] o_AUTO_SKIP,
  output pcor_pkg::pcor_mode_e o_CH5_MODE,
  output pcor_pkg::pcor_mode_e o_CH6_MODE,
  output logic o_HALF_GATE_CH1,
  output logic o_KEEPALIVE1_SUPPLY_PICK,
  output logic o_KEEPALIVE2_SUPPLY_PICK,
  output logic o_CH5_UV_STANDALONE,
  output logic o_CH5_UV_PROT_EN,
  output logic [pcor_pkg::DELAY_W-1:0] o_CH5_UV_DELAY_CYC,
  output logic o_CH1_LOW_RANGE,
  output logic o_POWER_DOWN_DELAY_X4,
  output logic [pcor_pkg::DIS_DELAY_W+1:0] o_DISABLE_DELAY_CYC,
  output logic o_CH3_ON,
  output logic o_MANUAL_ON_CH4
);

  localparam logic [pcor_pkg::DELAY_W-1:0] DLY_A = UV5_DELAY_A_CYC[pcor_pkg::DELAY_W-1:0];
  localparam logic [pcor_pkg::DELAY_W-1:0] DLY_B = UV5_DELAY_B_CYC[pcor_pkg::DELAY_W-1:0];

  pcor_pkg::pcor_state_e state;
  pcor_pkg::pcor_state_e next_state;
  logic fuse_load;
  logic wr_ok;

  logic [7:0] reg_auto_skip;
  logic [7:0] reg_edge_speed;
  logic [7:0] reg_mode_gate;
  logic [7:0] reg_keepalive;
  logic [7:0] reg_uv5;
  logic [7:0] reg_misc;

  logic wr_auto_skip;
  logic wr_edge_speed;
  logic wr_mode_gate;
  logic wr_keepalive;
  logic wr_uv5;
  logic wr_misc;

  // fuses are sampled by a clocked load after reset release, never by the reset itself
  assign fuse_load = (state == pcor_pkg::ST_FUSE_LOAD);
  assign next_state = pcor_pkg::ST_RUN;
  // writes are held off during the one-cycle load so a fuse value cannot overwrite them
  assign wr_ok = i_WR_EN && (state == pcor_pkg::ST_RUN);

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      state <= pcor_pkg::ST_FUSE_LOAD;
    else
      state <= next_state;
  end

  assign wr_auto_skip = wr_ok && (i_ADDR == pcor_pkg::ADDR_AUTO_SKIP);
  assign wr_edge_speed = wr_ok && (i_ADDR == pcor_pkg::ADDR_SWITCH_EDGE_SPEED);
  assign wr_mode_gate = wr_ok && (i_ADDR == pcor_pkg::ADDR_CONDUCTION_MODE_GATE_SIZE);
  assign wr_keepalive = wr_ok && (i_ADDR == pcor_pkg::ADDR_KEEPALIVE_INPUT_SELECT);
  assign wr_uv5 = wr_ok && (i_ADDR == pcor_pkg::ADDR_CH5_UNDERVOLTAGE_CONTROL);
  assign wr_misc = wr_ok && (i_ADDR == pcor_pkg::ADDR_MISC_OPTIONS);

  pcor_opt_reg #(
    .MASK(pcor_pkg::MASK_AUTO_SKIP),
    .RESET_VAL(pcor_pkg::RST_FUSED)
  ) u_auto_skip (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_load(fuse_load),
    .i_fuse(i_FUSE.auto_skip),
    .i_wr(wr_auto_skip),
    .i_wdata(i_WDATA),
    .o_q(reg_auto_skip)
  );

  // edge speed is not fused: it starts all-normal and stays so through the load
  pcor_opt_reg #(
    .MASK(pcor_pkg::MASK_SWITCH_EDGE_SPEED),
    .RESET_VAL(pcor_pkg::RST_SWITCH_EDGE_SPEED)
  ) u_edge_speed (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_load(1'b0),
    .i_fuse(pcor_pkg::RST_SWITCH_EDGE_SPEED),
    .i_wr(wr_edge_speed),
    .i_wdata(i_WDATA),
    .o_q(reg_edge_speed)
  );

  pcor_opt_reg #(
    .MASK(pcor_pkg::MASK_CONDUCTION_MODE_GATE_SIZE),
    .RESET_VAL(pcor_pkg::RST_FUSED)
  ) u_mode_gate (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_load(fuse_load),
    .i_fuse(i_FUSE.conduction_mode_gate_size),
    .i_wr(wr_mode_gate),
    .i_wdata(i_WDATA),
    .o_q(reg_mode_gate)
  );

  pcor_opt_reg #(
    .MASK(pcor_pkg::MASK_KEEPALIVE_INPUT_SELECT),
    .RESET_VAL(pcor_pkg::RST_FUSED)
  ) u_keepalive (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_load(fuse_load),
    .i_fuse(i_FUSE.keepalive_input_select),
    .i_wr(wr_keepalive),
    .i_wdata(i_WDATA),
    .o_q(reg_keepalive)
  );

  pcor_opt_reg #(
    .MASK(pcor_pkg::MASK_CH5_UNDERVOLTAGE_CONTROL),
    .RESET_VAL(pcor_pkg::RST_FUSED)
  ) u_uv5 (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_load(fuse_load),
    .i_fuse(i_FUSE.ch5_undervoltage_control),
    .i_wr(wr_uv5),
    .i_wdata(i_WDATA),
    .o_q(reg_uv5)
  );

  pcor_opt_reg #(
    .MASK(pcor_pkg::MASK_MISC_OPTIONS),
    .RESET_VAL(pcor_pkg::RST_FUSED)
  ) u_misc (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_load(fuse_load),
    .i_fuse(i_FUSE.misc_options),
    .i_wr(wr_misc),
    .i_wdata(i_WDATA),
    .o_q(reg_misc)
  );

  // read back; unmapped addresses answer zero
  logic [7:0] next_rdata;
  assign next_rdata =
    (i_RADDR == pcor_pkg::ADDR_AUTO_SKIP) ? reg_auto_skip :
    (i_RADDR == pcor_pkg::ADDR_SWITCH_EDGE_SPEED) ? reg_edge_speed :
    (i_RADDR == pcor_pkg::ADDR_CONDUCTION_MODE_GATE_SIZE) ? reg_mode_gate :
    (i_RADDR == pcor_pkg::ADDR_KEEPALIVE_INPUT_SELECT) ? reg_keepalive :
    (i_RADDR == pcor_pkg::ADDR_CH5_UNDERVOLTAGE_CONTROL) ? reg_uv5 :
    (i_RADDR == pcor_pkg::ADDR_MISC_OPTIONS) ? reg_misc :
    8'h00;

  // field extraction
  logic auto_skip_ch5;
  logic auto_skip_ch6;
  logic auto_discontinuous_ch5_ch6;
  logic ch5_undervolt_standalone;
  logic [1:0] ch5_undervolt_delay;
  logic pin_gate_off_ch3;
  logic pin_gate_off_ch4;

  assign auto_skip_ch5 = reg_auto_skip[pcor_pkg::POS_AUTO_SKIP_CH5];
  assign auto_skip_ch6 = reg_auto_skip[pcor_pkg::POS_AUTO_SKIP_CH6];
  assign auto_discontinuous_ch5_ch6 = reg_mode_gate[pcor_pkg::POS_AUTO_DISCONTINUOUS_CH5_CH6];
  assign ch5_undervolt_standalone = reg_uv5[pcor_pkg::POS_CH5_UNDERVOLT_STANDALONE];
  assign ch5_undervolt_delay =
    reg_uv5[pcor_pkg::POS_CH5_UNDERVOLT_DELAY_HI:pcor_pkg::POS_CH5_UNDERVOLT_DELAY_LO];
  assign pin_gate_off_ch3 = reg_misc[pcor_pkg::POS_PIN_GATE_OFF_CH3];
  assign pin_gate_off_ch4 = reg_misc[pcor_pkg::POS_PIN_GATE_OFF_CH4];

  // channel 5/6 operating mode; a channel left in forced PWM stays there even
  // if the shared DCM bit was set against the host's ordering
  pcor_pkg::pcor_mode_e next_ch5_mode;
  pcor_pkg::pcor_mode_e next_ch6_mode;
  assign next_ch5_mode = !auto_skip_ch5 ? pcor_pkg::MODE_FORCED_PWM :
    auto_discontinuous_ch5_ch6 ? pcor_pkg::MODE_AUTO_DCM : pcor_pkg::MODE_AUTO_PSM;
  assign next_ch6_mode = !auto_skip_ch6 ? pcor_pkg::MODE_FORCED_PWM :
    auto_discontinuous_ch5_ch6 ? pcor_pkg::MODE_AUTO_DCM : pcor_pkg::MODE_AUTO_PSM;

  // channel 5 undervoltage delay
  logic [pcor_pkg::DELAY_W-1:0] private_delay;
  logic [pcor_pkg::DELAY_W-1:0] next_uv_delay;
  logic next_uv_prot_en;
  assign private_delay =
    (ch5_undervolt_delay == pcor_pkg::UV5_CODE_A) ? DLY_A :
    (ch5_undervolt_delay == pcor_pkg::UV5_CODE_B) ? DLY_B :
    '0;
  assign next_uv_delay = ch5_undervolt_standalone ? private_delay : i_COMMON_UV_DELAY_CYC;
  // code 11 only switches off the standalone path; shared control keeps protection on
  assign next_uv_prot_en = !ch5_undervolt_standalone ||
    (ch5_undervolt_delay != pcor_pkg::UV5_CODE_OFF);

  // power-down delay scaling; output is two bits wider so nothing is lost
  logic [pcor_pkg::DIS_DELAY_W+1:0] next_dis_delay;
  assign next_dis_delay = reg_misc[pcor_pkg::POS_POWER_DOWN_DELAY_X4] ?
    {i_DISABLE_DELAY_CYC, 2'b00} : {2'b00, i_DISABLE_DELAY_CYC};

  // pin gating of manual enables for channels 3 and 4
  logic next_ch3_on;
  logic next_manual_on_ch4;
  assign next_ch3_on = i_MANUAL_ON_CH3 && (pin_gate_off_ch3 || i_CH3_CH4_ENABLE_PIN);
  assign next_manual_on_ch4 = i_MANUAL_ON_CH4 && (pin_gate_off_ch4 || i_CH3_CH4_ENABLE_PIN);

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_READY <= 1'b0;
      o_RDATA <= 8'h00;
      o_SLOW_EDGES <= 6'h00;
      o_AUTO_SKIP <= 6'h00;
      o_CH5_MODE <= pcor_pkg::MODE_FORCED_PWM;
      o_CH6_MODE <= pcor_pkg::MODE_FORCED_PWM;
      o_HALF_GATE_CH1 <= 1'b0;
      o_KEEPALIVE1_SUPPLY_PICK <= 1'b0;
      o_KEEPALIVE2_SUPPLY_PICK <= 1'b0;
      o_CH5_UV_STANDALONE <= 1'b0;
      o_CH5_UV_PROT_EN <= 1'b0;
      o_CH5_UV_DELAY_CYC <= '0;
      o_CH1_LOW_RANGE <= 1'b0;
      o_POWER_DOWN_DELAY_X4 <= 1'b0;
      o_DISABLE_DELAY_CYC <= '0;
      o_CH3_ON <= 1'b0;
      o_MANUAL_ON_CH4 <= 1'b0;
    end
    else
    begin
      o_READY <= (state == pcor_pkg::ST_RUN);
      o_RDATA <= next_rdata;
      o_SLOW_EDGES <= reg_edge_speed[5:0];
      o_AUTO_SKIP <= reg_auto_skip[5:0];
      o_CH5_MODE <= next_ch5_mode;
      o_CH6_MODE <= next_ch6_mode;
      o_HALF_GATE_CH1 <= reg_mode_gate[pcor_pkg::POS_HALF_GATE_CH1];
      o_KEEPALIVE1_SUPPLY_PICK <= reg_keepalive[pcor_pkg::POS_KEEPALIVE1_SUPPLY_PICK];
      o_KEEPALIVE2_SUPPLY_PICK <= reg_keepalive[pcor_pkg::POS_KEEPALIVE2_SUPPLY_PICK];
      o_CH5_UV_STANDALONE <= ch5_undervolt_standalone;
      o_CH5_UV_PROT_EN <= next_uv_prot_en;
      o_CH5_UV_DELAY_CYC <= next_uv_delay;
      o_CH1_LOW_RANGE <= reg_misc[pcor_pkg::POS_CH1_LOW_RANGE];
      o_POWER_DOWN_DELAY_X4 <= reg_misc[pcor_pkg::POS_POWER_DOWN_DELAY_X4];
      o_DISABLE_DELAY_CYC <= next_dis_delay;
      o_CH3_ON <= next_ch3_on;
      o_MANUAL_ON_CH4 <= next_manual_on_ch4;
    end
  end

endmodule // pcor_option_regs

// file: common/pcor_pkg.sv
package pcor_pkg;

  // register byte addresses on the serial register port
  localparam logic [7:0] ADDR_AUTO_SKIP = 8'h1C;
  localparam logic [7:0] ADDR_SWITCH_EDGE_SPEED = 8'h1F;
  localparam logic [7:0] ADDR_CONDUCTION_MODE_GATE_SIZE = 8'h20;
  localparam logic [7:0] ADDR_KEEPALIVE_INPUT_SELECT = 8'h21;
  localparam logic [7:0] ADDR_CH5_UNDERVOLTAGE_CONTROL = 8'h22;
  localparam logic [7:0] ADDR_MISC_OPTIONS = 8'h23;

  // implemented bits of each register; all others read zero
  localparam logic [7:0] MASK_AUTO_SKIP = 8'h3F;
  localparam logic [7:0] MASK_SWITCH_EDGE_SPEED = 8'h3F;
  localparam logic [7:0] MASK_CONDUCTION_MODE_GATE_SIZE = 8'h11;
  localparam logic [7:0] MASK_KEEPALIVE_INPUT_SELECT = 8'h11;
  localparam logic [7:0] MASK_CH5_UNDERVOLTAGE_CONTROL = 8'h31;
  localparam logic [7:0] MASK_MISC_OPTIONS = 8'h0F;

  // reset values before the fuse load
  localparam logic [7:0] RST_SWITCH_EDGE_SPEED = 8'h00;
  localparam logic [7:0] RST_FUSED = 8'h00;

  // field positions
  localparam int POS_AUTO_SKIP_CH5 = 4;
  localparam int POS_AUTO_SKIP_CH6 = 5;
  localparam int POS_AUTO_DISCONTINUOUS_CH5_CH6 = 4;
  localparam int POS_HALF_GATE_CH1 = 0;
  localparam int POS_KEEPALIVE2_SUPPLY_PICK = 4;
  localparam int POS_KEEPALIVE1_SUPPLY_PICK = 0;
  localparam int POS_CH5_UNDERVOLT_DELAY_LO = 4;
  localparam int POS_CH5_UNDERVOLT_DELAY_HI = 5;
  localparam int POS_CH5_UNDERVOLT_STANDALONE = 0;
  localparam int POS_CH1_LOW_RANGE = 3;
  localparam int POS_POWER_DOWN_DELAY_X4 = 2;
  localparam int POS_PIN_GATE_OFF_CH4 = 1;
  localparam int POS_PIN_GATE_OFF_CH3 = 0;

  // channel 5 private undervoltage delay codes
  localparam logic [1:0] UV5_CODE_NONE = 2'b00;
  localparam logic [1:0] UV5_CODE_A = 2'b01;
  localparam logic [1:0] UV5_CODE_B = 2'b10;
  localparam logic [1:0] UV5_CODE_OFF = 2'b11;

  // timing
  localparam int CLOCK_KHZ = 250000;
  localparam int UV5_DELAY_A_MS = 21;
  localparam int UV5_DELAY_B_MS = 45;
  localparam int UV5_DELAY_A_CYC = UV5_DELAY_A_MS * CLOCK_KHZ;
  localparam int UV5_DELAY_B_CYC = UV5_DELAY_B_MS * CLOCK_KHZ;
  localparam int DELAY_W = 24;
  localparam int DIS_DELAY_W = 16;
  localparam int DIS_DELAY_X4_SHIFT = 2;

  typedef enum logic [1:0] {
    MODE_FORCED_PWM = 2'b00,
    MODE_AUTO_PSM = 2'b01,
    MODE_AUTO_DCM = 2'b10
  } pcor_mode_e;

  typedef enum logic {
    ST_FUSE_LOAD = 1'b0,
    ST_RUN = 1'b1
  } pcor_state_e;

  // factory fuse image of the fused registers
  typedef struct packed {
    logic [7:0] auto_skip;
    logic [7:0] conduction_mode_gate_size;
    logic [7:0] keepalive_input_select;
    logic [7:0] ch5_undervoltage_control;
    logic [7:0] misc_options;
  } pcor_fuse_s;

endpackage

// file: hdl/pcor_opt_reg.sv
`timescale 1ns/1ps
module pcor_opt_reg #(
  parameter logic [7:0] MASK = 8'hFF,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [7:0] i_fuse,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q
);

  // masked bits never store, so they read back zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_q <= RESET_VAL & MASK;
    else if (i_load)
      o_q <= i_fuse & MASK;
    else if (i_wr)
      o_q <= i_wdata & MASK;
  end

endmodule // pcor_opt_reg

// file: testbench/pcor_host_model.sv
`timescale 1ns/1ps
module pcor_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic [7:0] o_raddr
);
  initial
  begin
    o_wr_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_raddr = 8'h00;
  end
  // one byte per strobe; lines turn over once released so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_raddr = a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask
  // both skip bits go up before the shared mode bit is set
  task automatic set_dcm(input logic [7:0] gate);
    wr(8'h1C, 8'h30);
    wr(8'h20, 8'h10 | gate);
  endtask
endmodule // pcor_host_model

// file: testbench/pcor_option_regs_sva.sv
`timescale 1ns/1ps
module pcor_option_regs_sva #(
  parameter int UV5_DELAY_A_CYC = 21,
  parameter int UV5_DELAY_B_CYC = 45
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic i_WR_EN,
  input wire logic [7:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  input wire logic [7:0] i_RADDR,
  input wire logic i_CH3_CH4_ENABLE_PIN,
  input wire logic i_MANUAL_ON_CH3,
  input wire logic [23:0] i_COMMON_UV_DELAY_CYC,
  input wire logic [15:0] i_DISABLE_DELAY_CYC,
  input wire logic o_READY,
  input wire logic [7:0] o_RDATA,
  input wire logic [5:0] o_SLOW_EDGES,
  input wire logic [5:0] o_AUTO_SKIP,
  input wire pcor_pkg::pcor_mode_e o_CH5_MODE,
  input wire pcor_pkg::pcor_mode_e o_CH6_MODE,
  input wire logic o_CH5_UV_STANDALONE,
  input wire logic o_CH5_UV_PROT_EN,
  input wire logic [23:0] o_CH5_UV_DELAY_CYC,
  input wire logic o_POWER_DOWN_DELAY_X4,
  input wire logic [17:0] o_DISABLE_DELAY_CYC,
  input wire logic o_CH3_ON
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  property p_ready;
    $past(I_RST_N) |=> o_READY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_slow;
    i_WR_EN && o_READY && i_ADDR == 8'h1F ##1 !i_WR_EN |=> o_SLOW_EDGES == $past(i_WDATA[5:0], 2);
  endproperty
  a_slow: assert property (p_slow) else $error("slew bits");
  property p_rdback;
    i_WR_EN && o_READY && i_ADDR == 8'h23 ##1 !i_WR_EN && i_RADDR == 8'h23
      |=> o_RDATA == ($past(i_WDATA, 2) & 8'h0F);
  endproperty
  a_rdback: assert property (p_rdback) else $error("readback");
  property p_unmapped;
    i_RADDR == 8'h40 |=> o_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_mode5;
    $past(o_READY) |-> (o_CH5_MODE == pcor_pkg::MODE_FORCED_PWM) == !o_AUTO_SKIP[4];
  endproperty
  a_mode5: assert property (p_mode5) else $error("ch5 mode");
  property p_pair;
    $past(o_READY) && o_AUTO_SKIP[5:4] == 2'b11
      |-> o_CH5_MODE == o_CH6_MODE && o_CH6_MODE != pcor_pkg::MODE_FORCED_PWM;
  endproperty
  a_pair: assert property (p_pair) else $error("shared mode");
  property p_uvcommon;
    $past(o_READY) && !o_CH5_UV_STANDALONE
      |-> o_CH5_UV_PROT_EN && o_CH5_UV_DELAY_CYC == $past(i_COMMON_UV_DELAY_CYC);
  endproperty
  a_uvcommon: assert property (p_uvcommon) else $error("common delay");
  property p_uvcode;
    $past(o_READY) && o_CH5_UV_STANDALONE |-> (o_CH5_UV_PROT_EN ?
      o_CH5_UV_DELAY_CYC inside {24'h0, UV5_DELAY_A_CYC, UV5_DELAY_B_CYC} :
      o_CH5_UV_DELAY_CYC == 24'h0);
  endproperty
  a_uvcode: assert property (p_uvcode) else $error("private delay");
  property p_dis;
    $past(o_READY) |-> o_DISABLE_DELAY_CYC == (o_POWER_DOWN_DELAY_X4 ?
      {$past(i_DISABLE_DELAY_CYC), 2'b00} : {2'b00, $past(i_DISABLE_DELAY_CYC)});
  endproperty
  a_dis: assert property (p_dis) else $error("disable delay");
  property p_ch3;
    $past(o_READY) && $past(i_CH3_CH4_ENABLE_PIN) |-> o_CH3_ON == $past(i_MANUAL_ON_CH3);
  endproperty
  a_ch3: assert property (p_ch3) else $error("ch3 enable");
endmodule // pcor_option_regs_sva
bind pcor_option_regs pcor_option_regs_sva #(
  .UV5_DELAY_A_CYC(UV5_DELAY_A_CYC),
  .UV5_DELAY_B_CYC(UV5_DELAY_B_CYC)
) u_sva (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .i_WR_EN(i_WR_EN), .i_ADDR(i_ADDR),
  .i_WDATA(i_WDATA), .i_RADDR(i_RADDR), .i_CH3_CH4_ENABLE_PIN(i_CH3_CH4_ENABLE_PIN),
  .i_MANUAL_ON_CH3(i_MANUAL_ON_CH3), .i_COMMON_UV_DELAY_CYC(i_COMMON_UV_DELAY_CYC),
  .i_DISABLE_DELAY_CYC(i_DISABLE_DELAY_CYC), .o_READY(o_READY), .o_RDATA(o_RDATA),
  .o_SLOW_EDGES(o_SLOW_EDGES), .o_AUTO_SKIP(o_AUTO_SKIP), .o_CH5_MODE(o_CH5_MODE),
  .o_CH6_MODE(o_CH6_MODE), .o_CH5_UV_STANDALONE(o_CH5_UV_STANDALONE),
  .o_CH5_UV_PROT_EN(o_CH5_UV_PROT_EN), .o_CH5_UV_DELAY_CYC(o_CH5_UV_DELAY_CYC),
  .o_POWER_DOWN_DELAY_X4(o_POWER_DOWN_DELAY_X4),
  .o_DISABLE_DELAY_CYC(o_DISABLE_DELAY_CYC), .o_CH3_ON(o_CH3_ON)
);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b0;
  logic man = 1'b1;
  logic [23:0] cuv = 24'h00ABCD;
  logic [15:0] ddl = 16'h1234;
  pcor_pkg::pcor_fuse_s fuse = '1;
  logic wr_en, ready, half, k1, k2, sa, pen, lowr, x4, ch3, ch4;
  logic [7:0] addr, wdata, raddr, rdata;
  logic [5:0] slow, skip;
  logic [23:0] uvd;
  logic [17:0] dd;
  pcor_pkg::pcor_mode_e m5, m6;
  logic [7:0] adr [6] = '{8'h1C, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23};
  logic [7:0] msk [6] = '{8'h3F, 8'h3F, 8'h11, 8'h11, 8'h31, 8'h0F};
  logic [23:0] uvx [4] = '{24'h0, 24'h15, 24'h2D, 24'h0};
  int error_cnt = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  pcor_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_addr(addr),
    .o_wdata(wdata), .o_raddr(raddr));
  // short delay codes keep the run brief; expectations use the same figures
  pcor_option_regs #(.UV5_DELAY_A_CYC(21), .UV5_DELAY_B_CYC(45)) u_dut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .i_WR_EN(wr_en), .i_ADDR(addr), .i_WDATA(wdata),
    .i_RADDR(raddr), .i_FUSE(fuse), .i_CH3_CH4_ENABLE_PIN(pin), .i_MANUAL_ON_CH3(man),
    .i_MANUAL_ON_CH4(man), .i_COMMON_UV_DELAY_CYC(cuv), .i_DISABLE_DELAY_CYC(ddl),
    .o_READY(ready), .o_RDATA(rdata), .o_SLOW_EDGES(slow), .o_AUTO_SKIP(skip),
    .o_CH5_MODE(m5), .o_CH6_MODE(m6), .o_HALF_GATE_CH1(half), .o_KEEPALIVE1_SUPPLY_PICK(k1),
    .o_KEEPALIVE2_SUPPLY_PICK(k2), .o_CH5_UV_STANDALONE(sa), .o_CH5_UV_PROT_EN(pen),
    .o_CH5_UV_DELAY_CYC(uvd), .o_CH1_LOW_RANGE(lowr), .o_POWER_DOWN_DELAY_X4(x4),
    .o_DISABLE_DELAY_CYC(dd), .o_CH3_ON(ch3), .o_MANUAL_ON_CH4(ch4));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk({16'h0, d}, {16'h0, exp});
  endtask
  // outputs follow one edge after the register takes the byte
  task automatic wo(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    chk(24'(m5), 24'(pcor_pkg::MODE_FORCED_PWM));
    #1 rst_n = 1'b1;
    // look off the edge so ready is never read while it is being launched
    for (int i = 0; i < 10 && ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (ready !== 1'b1)
    begin
      error_cnt++;
      finish_test();
    end
    #1;
    chk({22'h0, m6}, {22'h0, pcor_pkg::MODE_AUTO_DCM});
    for (int i = 0; i < 6; i++)
      rd(adr[i], i == 1 ? 8'h00 : msk[i]);
    // walk downwards so the shared mode bit is set while both skip bits are still one
    for (int i = 5; i >= 0; i--)
    begin
      wo(adr[i], 8'hFF);
      rd(adr[i], msk[i]);
      wo(adr[i], 8'h00);
      rd(adr[i], 8'h00);
    end
    wo(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wo(8'h1F, 8'h15);
    chk({18'h0, slow}, 24'h15);
    u_host.set_dcm(8'h01);
    wo(8'h21, 8'h10);
    chk({20'h0, m5, m6}, {20'h0, pcor_pkg::MODE_AUTO_DCM, pcor_pkg::MODE_AUTO_DCM});
    chk({21'h0, half, k2, k1}, 24'h6);
    wo(8'h20, 8'h00);
    chk({20'h0, m5, m6}, {20'h0, pcor_pkg::MODE_AUTO_PSM, pcor_pkg::MODE_AUTO_PSM});
    wo(8'h1C, 8'h10);
    chk({20'h0, m5, m6}, {20'h0, pcor_pkg::MODE_AUTO_PSM, pcor_pkg::MODE_FORCED_PWM});
    chk({18'h0, skip}, 24'h10);
    for (int c = 0; c < 4; c++)
    begin
      wo(8'h22, {2'b00, 2'(c), 4'h1});
      chk(uvd, uvx[c]);
      chk({22'h0, sa, pen}, {22'h0, 1'b1, c != 3});
    end
    wo(8'h22, 8'h30);
    chk(uvd, cuv);
    for (int g = 0; g < 4; g++)
    begin
      wo(8'h23, {4'h0, 2'b11, 2'(g)});
      chk({22'h0, ch4, ch3}, 24'(g));
      chk({4'h0, x4, lowr, dd}, {4'h0, 2'b11, ddl, 2'b00});
    end
    pin = 1'b1;
    wo(8'h23, 8'h00);
    chk({4'h0, ch4, ch3, dd}, {6'h3, 2'b00, ddl});
    man = 1'b0;
    wo(8'h23, 8'h03);
    chk({22'h0, ch4, ch3}, 24'h0);
    finish_test();
  end
endmodule // tb_top
